// File: rtl/pin_strap_regs.svh
`ifndef PIN_STRAP_REGS_SVH
`define PIN_STRAP_REGS_SVH

// ----------------------------------------
// Register offsets
// ----------------------------------------
`define CFG_OFF 8'h00
`define GPIO_OFF 8'h04
`define IR_OFF 8'h08
`define STAT_A_OFF 8'h0C
`define STAT_B_OFF 8'h10
`define MCTL_OFF 8'h14
`define DMA_OFF 8'h18

// ----------------------------------------
// Field positions and reset values
// ----------------------------------------
`define CFG_BIT_IRQ_GPIO 4
`define CFG_BIT_GAME_DMA 3
`define STAT_BIT_CTS 4
`define STAT_BIT_DSR 5
`define STAT_BIT_RI 6
`define STAT_BIT_DCD 7
`define CFG_RST 5'h06

// ----------------------------------------
// Timing
// ----------------------------------------
`define SYNC_STAGES 3

`endif

// File: rtl/pin_strap_pkg.sv
package pin_strap_pkg;

    // ----------------------------------------
    // Types
    // ----------------------------------------
    typedef logic [4:0] strap_cfg_t;

    typedef enum logic [6:0] {
        SEL_NONE = 7'h00,
        SEL_CFG = 7'h01,
        SEL_GPIO = 7'h02,
        SEL_IR = 7'h04,
        SEL_STAT_A = 7'h08,
        SEL_STAT_B = 7'h10,
        SEL_MCTL = 7'h20,
        SEL_DMA = 7'h40
    } reg_sel_t;

endpackage

// File: rtl/host_serial_pin_strap_mux.sv
// Added by the designer: the APB slave port and the register offsets.
`timescale 1ns/1ps
`include "pin_strap_regs.svh"

// Function
// - Select bit 0: pin drives IRQ A, else GPIO1
// - Select bit 0: pin drives IRQ B, else GPIO0
// - Active terminal count ends current DMA transfer
// - IR pin: fast receive input or select-0 output
// - CTS level readable in handshake status bit 4
// - DTR driven low means controller ready
// - RTS driven low means ready to send
// - Serial data in on SIN, out on SOUT
// - Reset samples port A serial out into bit 1
// - Reset samples port B serial out into bit 3
// - Reset samples port A DTR into bit 0
// - Reset samples port A RTS into bit 2
// - Reset samples port B RTS into bit 4
// - Game/DMA bit 0 gives game pins to DMA A
module host_serial_pin_strap_mux #(
    parameter int ADDR_W = 8
) (
    // Clock and reset
    input wire logic pclk,
    input wire logic presetn,
    // APB slave
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [ADDR_W-1:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    // Host side pins
    input wire logic master_reset_in,
    input wire logic dma_transfer_end,
    input wire logic irq_request_input,
    output logic dma_request_d,
    output logic ir_module_select_2,
    input wire logic ir_fast_rx_or_select_0_i,
    output logic ir_fast_rx_or_select_0_o,
    output logic ir_fast_rx_or_select_0_oe,
    input wire logic general_pin_1_i,
    output logic general_pin_1_o,
    output logic general_pin_1_oe,
    input wire logic general_pin_0_i,
    output logic general_pin_0_o,
    output logic general_pin_0_oe,
    output logic game_wr_or_dma_req,
    input wire logic game_rd_or_dma_ack_i,
    output logic game_rd_or_dma_ack_o,
    output logic game_rd_or_dma_ack_oe,
    // Modem pins
    input wire logic clear_to_send_port_a,
    input wire logic clear_to_send_port_b,
    input wire logic data_set_ready_port_a,
    input wire logic data_set_ready_port_b,
    input wire logic carrier_detect_port_a,
    input wire logic carrier_detect_port_b,
    input wire logic ring_indicator_port_a,
    input wire logic ring_indicator_port_b,
    input wire logic serial_in_port_a,
    input wire logic serial_in_port_b_ir,
    input wire logic serial_out_port_a_i,
    output logic serial_out_port_a_o,
    output logic serial_out_port_a_oe,
    input wire logic serial_out_port_b_i,
    output logic serial_out_port_b_o,
    output logic serial_out_port_b_oe,
    input wire logic terminal_ready_port_a_i,
    output logic terminal_ready_port_a_o,
    output logic terminal_ready_port_a_oe,
    output logic terminal_ready_port_b,
    input wire logic request_send_port_a_i,
    output logic request_send_port_a_o,
    output logic request_send_port_a_oe,
    input wire logic request_send_port_b_i,
    output logic request_send_port_b_o,
    output logic request_send_port_b_oe,
    // Internal function side
    input wire logic uart_a_txd,
    input wire logic uart_b_txd,
    input wire logic irq_a_req,
    input wire logic irq_b_req,
    input wire logic dma_req_a,
    input wire logic dma_req_d_in,
    input wire logic game_rd,
    input wire logic game_wr,
    output logic uart_a_rxd,
    output logic uart_b_rxd,
    output logic irq_request_seen,
    output logic dma_ack_a,
    output logic ir_fast_rx,
    output logic dma_end_pulse,
    output logic in_master_reset
);

    // ----------------------------------------
    // Pin input synchronisers
    // ----------------------------------------
    localparam int NS = 22;
    // Filters start at each pin's idle level, with master reset held, so no false edge follows reset.
    localparam logic [NS-1:0] SYNC_RST = 22'h00DFF9;

    logic [NS-1:0] async_in;
    logic [NS-1:0] filt;

    assign async_in = {game_rd_or_dma_ack_i, ir_fast_rx_or_select_0_i,
                       general_pin_1_i, general_pin_0_i,
                       request_send_port_b_i, serial_out_port_b_i,
                       request_send_port_a_i, serial_out_port_a_i,
                       terminal_ready_port_a_i,
                       serial_in_port_b_ir, serial_in_port_a,
                       ring_indicator_port_b, ring_indicator_port_a,
                       carrier_detect_port_b, carrier_detect_port_a,
                       data_set_ready_port_b, data_set_ready_port_a,
                       clear_to_send_port_b, clear_to_send_port_a,
                       irq_request_input, dma_transfer_end, master_reset_in};

    genvar gi;
    generate
        for (gi = 0; gi < NS; gi++) begin : g_sync
            logic [`SYNC_STAGES-1:0] sh_ff;
            logic filt_ff;
            always_ff @(posedge pclk or negedge presetn) begin
                if (!presetn) begin
                    sh_ff <= {`SYNC_STAGES{SYNC_RST[gi]}};
                    filt_ff <= SYNC_RST[gi];
                end else begin
                    sh_ff <= {sh_ff[`SYNC_STAGES-2:0], async_in[gi]};
                    // A change counts only once the last two stages agree.
                    if (sh_ff[1] == sh_ff[2]) begin
                        filt_ff <= sh_ff[2];
                    end
                end
            end
            assign filt[gi] = filt_ff;
        end
    endgenerate

    logic mr_f, tc_f, irq_request_input_f, cts_a_f, cts_b_f, dsr_a_f, dsr_b_f, dcd_a_f, dcd_b_f;
    logic ri_a_f, ri_b_f, sin_a_f, sin_b_f, gpio0_f, gpio1_f, ir_f, dack_a_f;
    pin_strap_pkg::strap_cfg_t strap_f;

    assign {dack_a_f, ir_f, gpio1_f, gpio0_f, strap_f, sin_b_f, sin_a_f, ri_b_f, ri_a_f,
            dcd_b_f, dcd_a_f, dsr_b_f, dsr_a_f, cts_b_f, cts_a_f, irq_request_input_f, tc_f, mr_f} = filt;

    // ----------------------------------------
    // APB decode
    // ----------------------------------------
    pin_strap_pkg::reg_sel_t sel;
    logic setup;
    logic wr;
    logic [31:0] nxt_rdata;

    always_comb begin
        unique case (paddr[7:0])
            `CFG_OFF: sel = pin_strap_pkg::SEL_CFG;
            `GPIO_OFF: sel = pin_strap_pkg::SEL_GPIO;
            `IR_OFF: sel = pin_strap_pkg::SEL_IR;
            `STAT_A_OFF: sel = pin_strap_pkg::SEL_STAT_A;
            `STAT_B_OFF: sel = pin_strap_pkg::SEL_STAT_B;
            `MCTL_OFF: sel = pin_strap_pkg::SEL_MCTL;
            `DMA_OFF: sel = pin_strap_pkg::SEL_DMA;
            default: sel = pin_strap_pkg::SEL_NONE;
        endcase
        if (paddr[ADDR_W-1:0] != ADDR_W'(paddr[7:0])) begin
            sel = pin_strap_pkg::SEL_NONE;
        end
    end

    assign setup = psel && !penable;
    assign wr = psel && penable && pready && pwrite;

    // ----------------------------------------
    // Control registers
    // ----------------------------------------
    pin_strap_pkg::strap_cfg_t cfg_ff;
    logic [1:0] gpio_out_ff;
    logic [1:0] gpio_dir_ff;
    logic [2:0] ir_ctl_ff;
    logic [3:0] mctl_ff;
    logic tc_prev_ff;
    logic tc_sticky_ff;
    logic tc_rise;

    // While master reset is held the straps are tracked; the value seen
    // last before release stays as the power-on value.
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            cfg_ff <= `CFG_RST;
        end else if (mr_f) begin
            cfg_ff <= strap_f;
        end else if (wr && sel == pin_strap_pkg::SEL_CFG) begin
            cfg_ff <= pwdata[4:0];
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            gpio_out_ff <= 2'h0;
            gpio_dir_ff <= 2'h0;
            ir_ctl_ff <= 3'h0;
            mctl_ff <= 4'h0;
        end else if (wr) begin
            if (sel == pin_strap_pkg::SEL_GPIO) begin
                gpio_out_ff <= pwdata[1:0];
                gpio_dir_ff <= pwdata[3:2];
            end
            if (sel == pin_strap_pkg::SEL_IR) begin
                ir_ctl_ff <= pwdata[2:0];
            end
            if (sel == pin_strap_pkg::SEL_MCTL) begin
                mctl_ff <= pwdata[3:0];
            end
        end
    end

    // ----------------------------------------
    // Transfer end tracking
    // ----------------------------------------
    assign tc_rise = tc_f && !tc_prev_ff;

    // A new end event in the clearing cycle keeps the flag set.
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            tc_prev_ff <= 1'b0;
            tc_sticky_ff <= 1'b0;
            dma_end_pulse <= 1'b0;
        end else begin
            tc_prev_ff <= tc_f;
            dma_end_pulse <= tc_rise;
            if (tc_rise) begin
                tc_sticky_ff <= 1'b1;
            end else if (wr && sel == pin_strap_pkg::SEL_DMA && pwdata[0]) begin
                tc_sticky_ff <= 1'b0;
            end
        end
    end

    // ----------------------------------------
    // APB answer
    // ----------------------------------------
    always_comb begin
        nxt_rdata = 32'h0;
        unique case (sel)
            pin_strap_pkg::SEL_CFG: nxt_rdata[4:0] = cfg_ff;
            pin_strap_pkg::SEL_GPIO: nxt_rdata[5:0] = {gpio1_f, gpio0_f, gpio_dir_ff, gpio_out_ff};
            pin_strap_pkg::SEL_IR: nxt_rdata[3:0] = {ir_f, ir_ctl_ff};
            pin_strap_pkg::SEL_STAT_A: begin
                nxt_rdata[`STAT_BIT_CTS] = cts_a_f;
                nxt_rdata[`STAT_BIT_DSR] = dsr_a_f;
                nxt_rdata[`STAT_BIT_RI] = ri_a_f;
                nxt_rdata[`STAT_BIT_DCD] = dcd_a_f;
            end
            pin_strap_pkg::SEL_STAT_B: begin
                nxt_rdata[`STAT_BIT_CTS] = cts_b_f;
                nxt_rdata[`STAT_BIT_DSR] = dsr_b_f;
                nxt_rdata[`STAT_BIT_RI] = ri_b_f;
                nxt_rdata[`STAT_BIT_DCD] = dcd_b_f;
            end
            pin_strap_pkg::SEL_MCTL: nxt_rdata[3:0] = mctl_ff;
            pin_strap_pkg::SEL_DMA: nxt_rdata[1:0] = {tc_f, tc_sticky_ff};
            pin_strap_pkg::SEL_NONE: nxt_rdata = 32'h0;
        endcase
    end

    // Answer is prepared in the setup cycle, so the access phase never waits.
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            prdata <= 32'h0;
            pready <= 1'b0;
            pslverr <= 1'b0;
        end else begin
            pready <= setup;
            pslverr <= setup && sel == pin_strap_pkg::SEL_NONE;
            if (setup && !pwrite) begin
                prdata <= nxt_rdata;
            end
        end
    end

    // ----------------------------------------
    // Pin drive
    // ----------------------------------------
    // Strap pins float during master reset so the pulls set their level.
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            serial_out_port_a_oe <= 1'b0;
            serial_out_port_b_oe <= 1'b0;
            terminal_ready_port_a_oe <= 1'b0;
            request_send_port_a_oe <= 1'b0;
            request_send_port_b_oe <= 1'b0;
            serial_out_port_a_o <= 1'b1;
            serial_out_port_b_o <= 1'b1;
            terminal_ready_port_a_o <= 1'b1;
            terminal_ready_port_b <= 1'b1;
            request_send_port_a_o <= 1'b1;
            request_send_port_b_o <= 1'b1;
        end else begin
            serial_out_port_a_oe <= !mr_f;
            serial_out_port_b_oe <= !mr_f;
            terminal_ready_port_a_oe <= !mr_f;
            request_send_port_a_oe <= !mr_f;
            request_send_port_b_oe <= !mr_f;
            serial_out_port_a_o <= uart_a_txd;
            serial_out_port_b_o <= uart_b_txd;
            terminal_ready_port_a_o <= !mctl_ff[0];
            request_send_port_a_o <= !mctl_ff[1];
            terminal_ready_port_b <= !mctl_ff[2];
            request_send_port_b_o <= !mctl_ff[3];
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            general_pin_1_o <= 1'b0;
            general_pin_1_oe <= 1'b0;
            general_pin_0_o <= 1'b0;
            general_pin_0_oe <= 1'b0;
        end else if (cfg_ff[`CFG_BIT_IRQ_GPIO]) begin
            general_pin_1_o <= gpio_out_ff[1];
            general_pin_1_oe <= gpio_dir_ff[1];
            general_pin_0_o <= gpio_out_ff[0];
            general_pin_0_oe <= gpio_dir_ff[0];
        end else begin
            general_pin_1_o <= irq_a_req;
            general_pin_1_oe <= 1'b1;
            general_pin_0_o <= irq_b_req;
            general_pin_0_oe <= 1'b1;
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            ir_fast_rx_or_select_0_o <= 1'b0;
            ir_fast_rx_or_select_0_oe <= 1'b0;
            ir_module_select_2 <= 1'b0;
            ir_fast_rx <= 1'b0;
        end else begin
            ir_fast_rx_or_select_0_oe <= ir_ctl_ff[0];
            ir_fast_rx_or_select_0_o <= ir_ctl_ff[1];
            ir_module_select_2 <= ir_ctl_ff[2];
            ir_fast_rx <= !ir_ctl_ff[0] && ir_f;
        end
    end

    // DMA A acknowledge idles high while the pins serve the game port.
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            game_wr_or_dma_req <= 1'b0;
            game_rd_or_dma_ack_o <= 1'b0;
            game_rd_or_dma_ack_oe <= 1'b0;
            dma_ack_a <= 1'b1;
        end else begin
            game_wr_or_dma_req <= cfg_ff[`CFG_BIT_GAME_DMA] ? game_wr : dma_req_a;
            game_rd_or_dma_ack_o <= game_rd;
            game_rd_or_dma_ack_oe <= cfg_ff[`CFG_BIT_GAME_DMA];
            dma_ack_a <= cfg_ff[`CFG_BIT_GAME_DMA] || dack_a_f;
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            uart_a_rxd <= 1'b1;
            uart_b_rxd <= 1'b1;
            irq_request_seen <= 1'b0;
            dma_request_d <= 1'b0;
            in_master_reset <= 1'b1;
        end else begin
            uart_a_rxd <= sin_a_f;
            uart_b_rxd <= sin_b_f;
            irq_request_seen <= irq_request_input_f;
            dma_request_d <= dma_req_d_in;
            in_master_reset <= mr_f;
        end
    end

    // ----------------------------------------
    // Checks
    // ----------------------------------------
    a_irq_a_route: assert property (@(posedge pclk) disable iff (!presetn)
        !cfg_ff[`CFG_BIT_IRQ_GPIO] ##1 !cfg_ff[`CFG_BIT_IRQ_GPIO] && $past(presetn)
        |-> general_pin_1_oe && general_pin_1_o == $past(irq_a_req))
        else $error("irq A pin not following request");
    a_gpio0_route: assert property (@(posedge pclk) disable iff (!presetn)
        cfg_ff[`CFG_BIT_IRQ_GPIO] |=> general_pin_0_oe == $past(gpio_dir_ff[0]))
        else $error("gpio 0 direction wrong");
    a_tc_sticky: assert property (@(posedge pclk) disable iff (!presetn)
        tc_rise |=> tc_sticky_ff && dma_end_pulse ##1 !dma_end_pulse)
        else $error("transfer end not recorded");
    a_ir_dir: assert property (@(posedge pclk) disable iff (!presetn)
        ir_ctl_ff[0] |=> ir_fast_rx_or_select_0_oe && !ir_fast_rx)
        else $error("ir pin direction wrong");
    a_cts_read: assert property (@(posedge pclk) disable iff (!presetn)
        setup && !pwrite && sel == pin_strap_pkg::SEL_STAT_A
        |=> pready && prdata[`STAT_BIT_CTS] == $past(cts_a_f))
        else $error("cts level not returned");
    a_dtr_drive: assert property (@(posedge pclk) disable iff (!presetn)
        !mr_f ##1 !mr_f |-> terminal_ready_port_a_oe
        && terminal_ready_port_a_o == !$past(mctl_ff[0]))
        else $error("dtr level wrong");
    a_sout_drive: assert property (@(posedge pclk) disable iff (!presetn)
        !mr_f |=> serial_out_port_a_o == $past(uart_a_txd) && serial_out_port_a_oe)
        else $error("serial out not driven");
    a_strap_capture: assert property (@(posedge pclk) disable iff (!presetn)
        mr_f |=> cfg_ff == $past(strap_f) && !serial_out_port_b_oe)
        else $error("strap not captured");
    a_strap_hold: assert property (@(posedge pclk) disable iff (!presetn)
        !mr_f && !(wr && sel == pin_strap_pkg::SEL_CFG) |=> $stable(cfg_ff))
        else $error("config changed without write");
    a_game_dma: assert property (@(posedge pclk) disable iff (!presetn)
        !cfg_ff[`CFG_BIT_GAME_DMA] |=> game_wr_or_dma_req == $past(dma_req_a)
        && !game_rd_or_dma_ack_oe)
        else $error("game pins not on dma");

endmodule

// File: dv/modem_link_model.sv
`timescale 1ns/1ps

// ----------------------------------------
// Board and modem beside the strap pins
// ----------------------------------------
module modem_link_model (
    // Strap pins as the design drives them
    input wire logic [4:0] strap_o,
    input wire logic [4:0] strap_oe,
    // Board resistors that may override the internal pulls
    input wire logic [4:0] resistor_en,
    input wire logic [4:0] resistor_val,
    output logic [4:0] strap_pin,
    // Modem state, one bit per port
    input wire logic [1:0] link_ready,
    input wire logic [1:0] carrier_seen,
    input wire logic [1:0] ringing,
    input wire logic [1:0] clear_send,
    output logic [1:0] ready_n,
    output logic [1:0] carrier_n,
    output logic [1:0] ring_n,
    output logic [1:0] cts_n
);
    // Bits 1 and 2 are pulled up, the others down.
    localparam logic [4:0] PULLS = 5'h06;

    // An undriven pin never keeps its last value: it falls to its pull or resistor.
    always_comb begin
        for (int i = 0; i < 5; i++) begin
            if (strap_oe[i]) begin
                strap_pin[i] = strap_o[i];
            end else begin
                strap_pin[i] = resistor_en[i] ? resistor_val[i] : PULLS[i];
            end
        end
    end

    assign ready_n = ~link_ready;
    assign carrier_n = ~carrier_seen;
    assign ring_n = ~ringing;
    assign cts_n = ~clear_send;
endmodule

// File: dv/testbench.sv
`timescale 1ns/1ps
`include "pin_strap_regs.svh"

`define CHK(nm, ex, got) begin tests_run++; if ((got) !== (ex)) begin error_cnt++; \
    $display("BAD %s exp %0h got %0h", nm, ex, got); end end

module testbench;
    // ----------------------------------------
    // Signals
    // ----------------------------------------
    logic pclk, presetn, psel, penable, pwrite, pready, pslverr;
    logic [7:0] paddr;
    logic [31:0] pwdata, prdata, rd;
    logic master_reset_in, dma_transfer_end, irq_request_input, dma_request_d, er;
    logic ir_module_select_2, ir_fast_rx_or_select_0_i, ir_fast_rx_or_select_0_o;
    logic ir_fast_rx_or_select_0_oe, general_pin_1_i, general_pin_1_o, general_pin_1_oe;
    logic general_pin_0_i, general_pin_0_o, general_pin_0_oe, game_wr_or_dma_req;
    logic game_rd_or_dma_ack_i, game_rd_or_dma_ack_o, game_rd_or_dma_ack_oe;
    logic clear_to_send_port_a, clear_to_send_port_b, data_set_ready_port_a;
    logic data_set_ready_port_b, carrier_detect_port_a, carrier_detect_port_b;
    logic ring_indicator_port_a, ring_indicator_port_b, serial_in_port_a, serial_in_port_b_ir;
    logic serial_out_port_a_i, serial_out_port_a_o, serial_out_port_a_oe;
    logic serial_out_port_b_i, serial_out_port_b_o, serial_out_port_b_oe;
    logic terminal_ready_port_a_i, terminal_ready_port_a_o, terminal_ready_port_a_oe;
    logic terminal_ready_port_b, request_send_port_a_i, request_send_port_a_o;
    logic request_send_port_a_oe, request_send_port_b_i, request_send_port_b_o;
    logic request_send_port_b_oe, uart_a_txd, uart_b_txd, irq_a_req, irq_b_req, dma_req_a;
    logic dma_req_d_in, game_rd, game_wr, uart_a_rxd, uart_b_rxd, irq_request_seen, dma_ack_a;
    logic ir_fast_rx, dma_end_pulse, in_master_reset, gp1_ext, gp0_ext, ir_ext, ack_ext;
    logic [4:0] strap_o, strap_oe, resistor_en, resistor_val, strap_pin;
    logic [1:0] link_ready, carrier_seen, ringing, clear_send, ready_n, carrier_n, ring_n, cts_n;
    int error_cnt = 0;
    int tests_run = 0;

    host_serial_pin_strap_mux i_dut (.*);
    modem_link_model i_partner (.*);

    assign strap_o = {request_send_port_b_o, serial_out_port_b_o, request_send_port_a_o,
        serial_out_port_a_o, terminal_ready_port_a_o};
    assign strap_oe = {request_send_port_b_oe, serial_out_port_b_oe, request_send_port_a_oe,
        serial_out_port_a_oe, terminal_ready_port_a_oe};
    assign {request_send_port_b_i, serial_out_port_b_i, request_send_port_a_i,
        serial_out_port_a_i, terminal_ready_port_a_i} = strap_pin;
    assign {clear_to_send_port_b, clear_to_send_port_a} = cts_n;
    assign {data_set_ready_port_b, data_set_ready_port_a} = ready_n;
    assign {carrier_detect_port_b, carrier_detect_port_a} = carrier_n;
    assign {ring_indicator_port_b, ring_indicator_port_a} = ring_n;
    assign general_pin_1_i = general_pin_1_oe ? general_pin_1_o : gp1_ext;
    assign general_pin_0_i = general_pin_0_oe ? general_pin_0_o : gp0_ext;
    assign ir_fast_rx_or_select_0_i = ir_fast_rx_or_select_0_oe ? ir_fast_rx_or_select_0_o : ir_ext;
    assign game_rd_or_dma_ack_i = game_rd_or_dma_ack_oe ? game_rd_or_dma_ack_o : ack_ext;

    always #5 pclk = ~pclk;

    // ----------------------------------------
    // Bus and helper tasks
    // ----------------------------------------
    task automatic end_of_test();
        $display("checks %0d mismatches %0d", tests_run, error_cnt);
        if (error_cnt == 0 && tests_run > 0) begin
            $display("[ PASS ]");
        end else begin
            $display("[ FAIL ]");
        end
        $finish;
    endtask

    task automatic fail_wait(input string what);
        error_cnt++;
        $display("BAD %s exp done got timeout", what);
        end_of_test();
    endtask

    task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] wd);
        int n;
        @(posedge pclk);
        psel <= 1'h1;
        penable <= 1'h0;
        pwrite <= wr;
        paddr <= a;
        pwdata <= wd;
        @(posedge pclk);
        penable <= 1'h1;
        n = 0;
        do begin
            @(posedge pclk);
            n++;
        end while (pready !== 1'h1 && n < 20);
        if (n == 20) fail_wait("pready");
        rd = prdata;
        er = pslverr;
        psel <= 1'h0;
        penable <= 1'h0;
    endtask

    task automatic mr_set(input logic lvl);
        int n;
        @(posedge pclk);
        master_reset_in <= lvl;
        n = 0;
        do begin
            @(posedge pclk);
            n++;
        end while (in_master_reset !== lvl && n < 20);
        if (n == 20) fail_wait("in_master_reset");
    endtask

    // ----------------------------------------
    // Scenarios
    // ----------------------------------------
    task automatic t_strap();
        @(negedge pclk);
        `CHK("strap_oe", 5'h00, strap_oe)
        mr_set(1'h0);
        apb(1'h0, `CFG_OFF, 32'h00);
        `CHK("cfg", 32'h06, rd)
        `CHK("strap_oe", 5'h1F, strap_oe)
        @(posedge pclk);
        resistor_en <= 5'h1F;
        resistor_val <= 5'h19;
        mr_set(1'h1);
        mr_set(1'h0);
        resistor_en <= 5'h00;
        apb(1'h0, `CFG_OFF, 32'h00);
        `CHK("cfg", 32'h19, rd)
        apb(1'h1, `CFG_OFF, 32'h0B);
        apb(1'h0, `CFG_OFF, 32'h00);
        `CHK("cfg", 32'h0B, rd)
        apb(1'h0, 8'h1C, 32'h00);
        `CHK("slverr", 1'h1, er)
        $display("test strap done");
    endtask

    task automatic t_irq_gpio();
        apb(1'h1, `CFG_OFF, 32'h00);
        irq_a_req <= 1'h1;
        gp0_ext <= 1'h1;
        repeat (2) @(negedge pclk);
        `CHK("pin1", 2'h3, {general_pin_1_oe, general_pin_1_o})
        `CHK("pin0", 2'h2, {general_pin_0_oe, general_pin_0_o})
        apb(1'h1, `CFG_OFF, 32'h10);
        apb(1'h1, `GPIO_OFF, 32'h0A);
        repeat (6) @(negedge pclk);
        `CHK("pin1", 2'h3, {general_pin_1_oe, general_pin_1_o})
        `CHK("pin0_oe", 1'h0, general_pin_0_oe)
        apb(1'h0, `GPIO_OFF, 32'h00);
        `CHK("gpio", 32'h3A, rd)
        $display("test irq_gpio done");
    endtask

    task automatic t_dma();
        int n;
        @(posedge pclk);
        dma_transfer_end <= 1'h1;
        n = 0;
        do begin
            @(negedge pclk);
            n++;
        end while (dma_end_pulse !== 1'h1 && n < 20);
        if (n == 20) fail_wait("dma_end_pulse");
        @(negedge pclk);
        `CHK("end_pulse", 1'h0, dma_end_pulse)
        apb(1'h0, `DMA_OFF, 32'h00);
        `CHK("dma", 32'h03, rd)
        dma_transfer_end <= 1'h0;
        repeat (6) @(posedge pclk);
        apb(1'h1, `DMA_OFF, 32'h01);
        apb(1'h0, `DMA_OFF, 32'h00);
        `CHK("dma", 32'h00, rd)
        $display("test dma done");
    endtask

    task automatic t_ir();
        apb(1'h1, `IR_OFF, 32'h07);
        repeat (2) @(negedge pclk);
        `CHK("ir_out", 3'h7, {ir_module_select_2, ir_fast_rx_or_select_0_oe,
            ir_fast_rx_or_select_0_o})
        apb(1'h1, `IR_OFF, 32'h00);
        ir_ext <= 1'h1;
        repeat (6) @(negedge pclk);
        `CHK("ir_fast_rx", 1'h1, ir_fast_rx)
        apb(1'h0, `IR_OFF, 32'h00);
        `CHK("ir", 32'h08, rd)
        $display("test ir done");
    endtask

    task automatic t_modem();
        @(posedge pclk);
        clear_send <= 2'h1;
        ringing <= 2'h1;
        link_ready <= 2'h2;
        carrier_seen <= 2'h2;
        uart_a_txd <= 1'h0;
        serial_in_port_b_ir <= 1'h0;
        irq_request_input <= 1'h1;
        apb(1'h1, `MCTL_OFF, 32'h05);
        repeat (6) @(negedge pclk);
        `CHK("dtr_rts", 4'h3, {terminal_ready_port_a_o, terminal_ready_port_b,
            request_send_port_a_o, request_send_port_b_o})
        `CHK("txd_a", 1'h0, serial_out_port_a_o)
        `CHK("rxd", 3'h5, {uart_a_rxd, uart_b_rxd, irq_request_seen})
        apb(1'h0, `STAT_A_OFF, 32'h00);
        `CHK("stat_a", 32'hA0, rd)
        apb(1'h0, `STAT_B_OFF, 32'h00);
        `CHK("stat_b", 32'h50, rd)
        apb(1'h1, `MCTL_OFF, 32'h0A);
        repeat (2) @(negedge pclk);
        `CHK("dtr_rts", 4'hC, {terminal_ready_port_a_o, terminal_ready_port_b,
            request_send_port_a_o, request_send_port_b_o})
        $display("test modem done");
    endtask

    task automatic t_game();
        apb(1'h1, `CFG_OFF, 32'h00);
        dma_req_a <= 1'h1;
        dma_req_d_in <= 1'h1;
        game_rd <= 1'h1;
        repeat (6) @(negedge pclk);
        `CHK("game_dma", 5'h13, {game_wr_or_dma_req, game_rd_or_dma_ack_oe, dma_ack_a,
            game_rd_or_dma_ack_o, dma_request_d})
        apb(1'h1, `CFG_OFF, 32'h08);
        repeat (6) @(negedge pclk);
        `CHK("game_dma", 5'h0F, {game_wr_or_dma_req, game_rd_or_dma_ack_oe, dma_ack_a,
            game_rd_or_dma_ack_o, dma_request_d})
        $display("test game done");
    endtask

    // ----------------------------------------
    // Main sequence
    // ----------------------------------------
    initial begin
        {pclk, presetn, psel, penable, pwrite, paddr, pwdata} = '0;
        {dma_transfer_end, irq_request_input, irq_a_req, irq_b_req, dma_req_a} = '0;
        {dma_req_d_in, game_rd, game_wr, gp1_ext, gp0_ext, ir_ext, ack_ext} = '0;
        {uart_a_txd, uart_b_txd, serial_in_port_a, serial_in_port_b_ir} = 4'hF;
        {resistor_en, resistor_val, link_ready, carrier_seen, ringing, clear_send} = '0;
        master_reset_in = 1'h1;
        repeat (16) @(posedge pclk);
        presetn <= 1'h1;
        t_strap();
        t_irq_gpio();
        t_dma();
        t_ir();
        t_modem();
        t_game();
        end_of_test();
    end
endmodule
